// *** hdl/fec_pkg.sv ***
// shared constants and types of the flash erase command handler
package fec_pkg;

  // ----------------------------------------------------------------------
  // framing bytes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FRAME_START_BYTE  = 8'h01;
  localparam logic [7:0]  FRAME_END_BYTE    = 8'h03;
  localparam logic [7:0]  REPLY_START_BYTE  = 8'h81;
  localparam logic [7:0]  ERASE_CMD_CODE    = 8'h12;
  localparam logic [7:0]  ERASE_ERR_CODE    = 8'h92;
  localparam logic [7:0]  RESULT_OK         = 8'h00;
  localparam logic [15:0] ERASE_CMD_LENGTH  = 16'h0009;
  localparam logic [7:0]  REPLY_LEN_HIGH    = 8'h00;
  localparam logic [7:0]  REPLY_LEN_LOW     = 8'h0A;
  localparam logic [31:0] UNUSED_WORD       = 32'hFFFFFFFF;

  // ----------------------------------------------------------------------
  // byte positions, counted from the byte after the start byte
  // ----------------------------------------------------------------------
  localparam logic [3:0] POS_LEN_HIGH   = 4'h0;
  localparam logic [3:0] POS_LEN_LOW    = 4'h1;
  localparam logic [3:0] POS_CMD        = 4'h2;
  localparam logic [3:0] POS_BEGIN_LAST = 4'h6;
  localparam logic [3:0] POS_FINAL_LAST = 4'hA;
  localparam logic [3:0] POS_SUM        = 4'hB;
  localparam logic [3:0] POS_END        = 4'hC;

  // reply byte positions, counted from the reply start byte
  localparam logic [3:0] RPOS_SUM       = 4'hD;
  localparam logic [3:0] RPOS_END       = 4'hE;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] range_begin_address;
    logic [31:0] range_final_address;
    logic [7:0]  area_kind;
    logic [31:0] erase_unit_size;
  } fec_area_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] range_begin_address;
    logic [31:0] range_final_address;
  } fec_range_t;

  typedef struct packed {
    logic        hit;
    logic [7:0]  area_kind;
    logic [31:0] erase_unit_size;
  } fec_area_hit_t;

  // closes a running byte sum into the checksum byte
  function automatic logic [7:0] fec_sum_close(input logic [7:0] acc,
                                               input logic       twos);
    fec_sum_close = twos ? 8'((~acc) + 8'h01) : acc;
  endfunction

endpackage

// *** hdl/fec_area_lookup.sv ***
// finds the area that holds one address
`timescale 1ns/100ps
module fec_area_lookup #(
  parameter int NUM_AREAS = 4
) (
  input  wire logic [31:0]            addr_i,
  input  wire fec_pkg::fec_area_t [NUM_AREAS-1:0] area_table_i,
  output fec_pkg::fec_area_hit_t      hit_o
);

  // first matching entry wins
  always_comb begin
    hit_o = '0;
    for (int i = NUM_AREAS - 1; i >= 0; i--) begin
      if (addr_i >= area_table_i[i].range_begin_address &&
          addr_i <= area_table_i[i].range_final_address) begin
        hit_o.hit             = 1'b1;
        hit_o.area_kind       = area_table_i[i].area_kind;
        hit_o.erase_unit_size = area_table_i[i].erase_unit_size;
      end
    end
  end

endmodule // fec_area_lookup

// *** hdl/fec_erase_handler.sv ***
// erase command interpreter: frame check, erase sequencing, status reply
`timescale 1ns/100ps
module fec_erase_handler #(
  parameter int         NUM_AREAS        = 4,
  parameter bit         HAS_LIFECYCLE    = 1'b1,
  parameter bit         SUM_TWOS         = 1'b1,
  parameter logic [7:0] NONSECURE_DEBUG  = 8'h03,
  parameter logic [7:0] ST_PACKET_ERR    = 8'hC1,
  parameter logic [7:0] ST_CHECKSUM_ERR  = 8'hC2,
  parameter logic [7:0] ST_ACCEPT_ERR    = 8'hC3,
  parameter logic [7:0] ST_PARAM_ERR     = 8'hC4,
  parameter logic [7:0] ST_SECURE_ERR    = 8'hC5,
  parameter logic [7:0] ST_PROTECT_ERR   = 8'hC6,
  parameter logic [7:0] ST_FLASH_ERR     = 8'hC7
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // received byte stream
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  output logic             rx_ready_o,
  // reply byte stream
  output logic             tx_valid_o,
  output logic [7:0]       tx_byte_o,
  input  wire logic        tx_ready_i,
  // device state
  input  wire logic [7:0]  lifecycle_state_i,
  input  wire logic        cmd_permitted_i,
  input  wire logic        debug_id_lock_i,
  input  wire logic        id_authenticated_i,
  input  wire fec_pkg::fec_area_t [NUM_AREAS-1:0] area_table_i,
  input  wire fec_pkg::fec_range_t secure_region_i,
  input  wire fec_pkg::fec_range_t perm_protect_i,
  // flash sequencer unit
  output logic             erase_req_o,
  output logic [31:0]      erase_addr_o,
  input  wire logic        erase_done_i,
  input  wire logic        erase_fault_i,
  input  wire logic [31:0] flash_status_i,
  output logic             busy_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_RECV  = 5'b00010,
    S_CHECK = 5'b00100,
    S_ERASE = 5'b01000,
    S_REPLY = 5'b10000
  } fec_state_t;

  typedef struct packed {
    fec_state_t  state;
    logic [3:0]  cnt;
    logic [15:0] len;
    logic [7:0]  cmd;
    logic [31:0] range_begin_address;
    logic [31:0] range_final_address;
    logic [7:0]  acc;
    logic [7:0]  sum_rx;
    logic        end_ok;
    logic [31:0] cur;
    logic [31:0] unit;
    logic        req;
    logic [7:0]  response_code;
    logic [7:0]  result_code;
    logic [31:0] result_detail_word;
    logic [31:0] fail_addr;
    logic [7:0]  txb;
  } fec_regs_t;

  localparam fec_regs_t REGS_RESET = '{
    state: S_IDLE, cnt: 4'h0, len: 16'h0000, cmd: 8'h00,
    range_begin_address: 32'h00000000, range_final_address: 32'h00000000,
    acc: 8'h00, sum_rx: 8'h00, end_ok: 1'b0, cur: 32'h00000000,
    unit: 32'h00000000, req: 1'b0, response_code: 8'h00,
    result_code: 8'h00, result_detail_word: 32'h00000000,
    fail_addr: 32'h00000000, txb: 8'h00};

  fec_regs_t              r;
  fec_regs_t              next_r;
  fec_pkg::fec_area_hit_t begin_hit;
  fec_pkg::fec_area_hit_t final_hit;

  // ----------------------------------------------------------------------
  // area lookups of both range ends
  // ----------------------------------------------------------------------
  fec_area_lookup #(.NUM_AREAS(NUM_AREAS)) u_begin_lookup (
    .addr_i       (r.range_begin_address),
    .area_table_i (area_table_i),
    .hit_o        (begin_hit)
  );

  fec_area_lookup #(.NUM_AREAS(NUM_AREAS)) u_final_lookup (
    .addr_i       (r.range_final_address),
    .area_table_i (area_table_i),
    .hit_o        (final_hit)
  );

  // ----------------------------------------------------------------------
  // reply byte selection
  // ----------------------------------------------------------------------
  function automatic logic [7:0] reply_byte(input fec_regs_t  s,
                                            input logic [3:0] idx,
                                            input logic [7:0] acc);
    logic [7:0] b;
    b = fec_pkg::FRAME_END_BYTE;
    unique case (idx)
      4'h0: b = fec_pkg::REPLY_START_BYTE;
      4'h1: b = fec_pkg::REPLY_LEN_HIGH;
      4'h2: b = fec_pkg::REPLY_LEN_LOW;
      4'h3: b = s.response_code;
      4'h4: b = s.result_code;
      4'h5: b = s.result_detail_word[31:24];
      4'h6: b = s.result_detail_word[23:16];
      4'h7: b = s.result_detail_word[15:8];
      4'h8: b = s.result_detail_word[7:0];
      4'h9: b = s.fail_addr[31:24];
      4'hA: b = s.fail_addr[23:16];
      4'hB: b = s.fail_addr[15:8];
      4'hC: b = s.fail_addr[7:0];
      fec_pkg::RPOS_SUM: b = fec_pkg::fec_sum_close(acc, SUM_TWOS);
      default: b = fec_pkg::FRAME_END_BYTE;
    endcase
    reply_byte = b;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic [32:0] unit_last;
  logic [31:0] begin_mask;
  logic [31:0] final_mask;
  logic [31:0] final_plus;
  logic        fail;
  logic [7:0]  fail_code;

  always_comb begin
    next_r     = r;
    fail       = 1'b0;
    fail_code  = ST_PACKET_ERR;
    begin_mask = begin_hit.erase_unit_size - 32'h00000001;
    final_mask = final_hit.erase_unit_size - 32'h00000001;
    final_plus = r.range_final_address + 32'h00000001;
    unit_last  = {1'b0, r.cur} + {1'b0, r.unit} - 33'h000000001;

    unique case (r.state)
      S_IDLE: begin
        if (rx_valid_i && rx_byte_i == fec_pkg::FRAME_START_BYTE) begin
          next_r.state = S_RECV;
          next_r.cnt   = 4'h0;
          next_r.acc   = 8'h00;
        end
      end

      S_RECV: begin
        if (rx_valid_i) begin
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt < fec_pkg::POS_SUM) begin
            next_r.acc = r.acc + rx_byte_i;
          end
          if (r.cnt == fec_pkg::POS_LEN_HIGH) begin
            next_r.len[15:8] = rx_byte_i;
          end
          if (r.cnt == fec_pkg::POS_LEN_LOW) begin
            next_r.len[7:0] = rx_byte_i;
          end
          if (r.cnt == fec_pkg::POS_CMD) begin
            next_r.cmd = rx_byte_i;
          end
          if (r.cnt > fec_pkg::POS_CMD &&
              r.cnt <= fec_pkg::POS_BEGIN_LAST) begin
            next_r.range_begin_address = {r.range_begin_address[23:0],
                                          rx_byte_i};
          end
          if (r.cnt > fec_pkg::POS_BEGIN_LAST &&
              r.cnt <= fec_pkg::POS_FINAL_LAST) begin
            next_r.range_final_address = {r.range_final_address[23:0],
                                          rx_byte_i};
          end
          if (r.cnt == fec_pkg::POS_SUM) begin
            next_r.sum_rx = rx_byte_i;
          end
          if (r.cnt == fec_pkg::POS_END) begin
            next_r.end_ok = (rx_byte_i == fec_pkg::FRAME_END_BYTE);
            next_r.state  = S_CHECK;
          end
        end
      end

      S_CHECK: begin
        // checks in falling priority; the first one to fail is reported
        if (!r.end_ok) begin
          fail = 1'b1;
          fail_code = ST_PACKET_ERR;
        end else if (r.sum_rx !=
                     fec_pkg::fec_sum_close(r.acc, SUM_TWOS)) begin
          fail = 1'b1;
          fail_code = ST_CHECKSUM_ERR;
        end else if (r.len == 16'h0000 ||
                     r.len != fec_pkg::ERASE_CMD_LENGTH) begin
          fail = 1'b1;
          fail_code = ST_PACKET_ERR;
        end else if (HAS_LIFECYCLE ? !cmd_permitted_i
                     : (debug_id_lock_i && !id_authenticated_i)) begin
          fail = 1'b1;
          fail_code = ST_ACCEPT_ERR;
        end else if (r.range_begin_address >
                     r.range_final_address) begin
          fail = 1'b1;
          fail_code = ST_PARAM_ERR;
        end else if (!begin_hit.hit || !final_hit.hit) begin
          fail = 1'b1;
          fail_code = ST_PARAM_ERR;
        end else if (begin_hit.area_kind != final_hit.area_kind) begin
          fail = 1'b1;
          fail_code = ST_PARAM_ERR;
        end else if (begin_hit.erase_unit_size == 32'h00000000 ||
                     final_hit.erase_unit_size == 32'h00000000) begin
          fail = 1'b1;
          fail_code = ST_PARAM_ERR;
        end else if ((r.range_begin_address & begin_mask) != 32'h0 ||
                     (final_plus & final_mask) != 32'h0) begin
          fail = 1'b1;
          fail_code = ST_PARAM_ERR;
        end else if (HAS_LIFECYCLE && secure_region_i.valid &&
                     lifecycle_state_i == NONSECURE_DEBUG &&
                     r.range_begin_address <=
                       secure_region_i.range_final_address &&
                     r.range_final_address >=
                       secure_region_i.range_begin_address) begin
          fail = 1'b1;
          fail_code = ST_SECURE_ERR;
        end else if (perm_protect_i.valid &&
                     r.range_begin_address <=
                       perm_protect_i.range_final_address &&
                     r.range_final_address >=
                       perm_protect_i.range_begin_address) begin
          fail = 1'b1;
          fail_code = ST_PROTECT_ERR;
        end

        next_r.result_detail_word = fec_pkg::UNUSED_WORD;
        next_r.fail_addr          = fec_pkg::UNUSED_WORD;
        if (r.end_ok && r.cmd != fec_pkg::ERASE_CMD_CODE) begin
          // another command's frame: not ours to answer
          next_r.state = S_IDLE;
        end else if (fail) begin
          next_r.state         = S_REPLY;
          next_r.response_code = fec_pkg::ERASE_ERR_CODE;
          next_r.result_code   = fail_code;
        end else begin
          next_r.state = S_ERASE;
          next_r.cur   = r.range_begin_address;
          next_r.unit  = begin_hit.erase_unit_size;
          next_r.req   = 1'b1;
        end
        next_r.cnt = 4'h0;
        next_r.acc = 8'h00;
      end

      S_ERASE: begin
        if (erase_done_i) begin
          next_r.req = 1'b0;
          if (erase_fault_i) begin
            next_r.state              = S_REPLY;
            next_r.response_code      = fec_pkg::ERASE_ERR_CODE;
            next_r.result_code        = ST_FLASH_ERR;
            next_r.result_detail_word = flash_status_i;
            next_r.fail_addr          = r.cur;
          end else if (unit_last >= {1'b0, r.range_final_address}) begin
            next_r.state         = S_REPLY;
            next_r.response_code = fec_pkg::ERASE_CMD_CODE;
            next_r.result_code   = fec_pkg::RESULT_OK;
          end else begin
            next_r.cur = r.cur + r.unit;
            next_r.req = 1'b1;
          end
        end
      end

      S_REPLY: begin
        if (tx_ready_i) begin
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt != 4'h0) begin
            next_r.acc = r.acc + r.txb;
          end
          if (r.cnt == fec_pkg::RPOS_END) begin
            next_r.state = S_IDLE;
          end
        end
      end
    endcase

    // reply byte register follows the reply position
    next_r.txb = reply_byte(next_r, next_r.cnt, next_r.acc);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rx_ready_o   = (r.state == S_IDLE) || (r.state == S_RECV);
  assign tx_valid_o   = (r.state == S_REPLY);
  assign tx_byte_o    = r.txb;
  assign erase_req_o  = r.req;
  assign erase_addr_o = r.cur;
  assign busy_o       = (r.state != S_IDLE);

endmodule // fec_erase_handler

// *** verif/fec_erase_handler_assertions.sv ***
// property checks on the erase handler ports
`timescale 1ns/100ps
module fec_erase_handler_assertions #(
  parameter int NUM_AREAS = 4
) (
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic        rx_valid_i,
  input wire logic [7:0]  rx_byte_i,
  input wire logic        rx_ready_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_byte_o,
  input wire logic        tx_ready_i,
  input wire logic        erase_req_o,
  input wire logic [31:0] erase_addr_o,
  input wire logic        erase_done_i,
  input wire logic        erase_fault_i,
  input wire logic        busy_o
);
  logic [3:0] pos;
  logic       erased;
  logic       faulted;
  logic       take;

  assign take = tx_valid_o && tx_ready_i;

  // ----------------------------------------------------------------
  // reply index and erase history of the current command
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !busy_o) begin
      pos     <= 4'h0;
      erased  <= 1'b0;
      faulted <= 1'b0;
    end else begin
      pos     <= take ? pos + 4'h1 : pos;
      erased  <= erased | erase_req_o;
      faulted <= faulted | (erase_done_i & erase_fault_i);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_start_byte: assert property (
    !busy_o && rx_valid_i && rx_ready_o
    |=> busy_o == ($past(rx_byte_i) == fec_pkg::FRAME_START_BYTE))
    else $error("start byte handling wrong");
  a_req_hold: assert property (
    erase_req_o && !erase_done_i |=> erase_req_o && $stable(erase_addr_o))
    else $error("erase request dropped or moved");
  a_addr_rise: assert property (
    erase_req_o && erase_done_i
    |=> !erase_req_o || erase_addr_o > $past(erase_addr_o))
    else $error("erase address not ascending");
  a_fault_stop: assert property (
    erase_req_o && erase_done_i && erase_fault_i
    |=> !erase_req_o ##[0:2] tx_valid_o)
    else $error("erase went on after fault");
  a_erase_quiet: assert property (
    erase_req_o |-> !tx_valid_o && !rx_ready_o)
    else $error("erase overlaps traffic");
  a_reply_head: assert property (
    $rose(tx_valid_o) |-> tx_byte_o == fec_pkg::REPLY_START_BYTE)
    else $error("reply start byte wrong");
  a_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("reply byte not held");
  a_len_low: assert property (
    take && pos == 4'h2 |-> tx_byte_o == fec_pkg::REPLY_LEN_LOW)
    else $error("reply length wrong");
  a_err_no_erase: assert property (
    take && pos == 4'h3 && !erased |-> tx_byte_o == fec_pkg::ERASE_ERR_CODE)
    else $error("ok reply without erase");
  a_ok_code: assert property (
    take && pos == 4'h3 && erased && !faulted
    |-> tx_byte_o == fec_pkg::ERASE_CMD_CODE)
    else $error("clean erase not answered ok");
  a_reply_done: assert property (
    take && pos == 4'hE |=> !busy_o && rx_ready_o)
    else $error("not idle after reply");
endmodule // fec_erase_handler_assertions

bind fec_erase_handler fec_erase_handler_assertions #(
  .NUM_AREAS(NUM_AREAS)
) u_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .rx_valid_i(rx_valid_i),
  .rx_byte_i(rx_byte_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
  .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i), .erase_req_o(erase_req_o),
  .erase_addr_o(erase_addr_o), .erase_done_i(erase_done_i),
  .erase_fault_i(erase_fault_i), .busy_o(busy_o)
);

// *** verif/fec_host_model.sv ***
// host programmer model: sends command bytes, collects reply bytes
`timescale 1ns/100ps
module fec_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rx_ready_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_byte_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            tx_ready_o
);
  int         seed = 67;
  logic [7:0] q[$];

  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'hA5;
    tx_ready_o = 1'b0;
  end

  // one byte, held until taken
  task automatic send(input logic [7:0] b);
    rx_valid_o <= 1'b1;
    rx_byte_o  <= b;
    do @(posedge sys_clk_i); while (rx_ready_i !== 1'b1);
  endtask

  // released data line shows no stale byte
  task automatic idle();
    rx_valid_o <= 1'b0;
    rx_byte_o  <= ~rx_byte_o;
  endtask

  // reply sink with random stalls
  always @(posedge sys_clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) q.push_back(tx_byte_i);
    tx_ready_o <= 1'($random(seed));
  end
endmodule // fec_host_model

// *** verif/tb_flash_erase_command_handler.sv ***
// self-checking bench for the erase command handler
`timescale 1ns/100ps
module tb_flash_erase_command_handler;
  localparam logic [7:0]  NSD   = 8'h05;
  // packet, sum, accept, param, secure, protect, flash
  localparam logic [7:0]  ST[7] = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5,
                                   8'hA6, 8'hA7};
  localparam logic [31:0] AB[4] = '{32'h0, 32'h8000000, 32'h9000000,
                                   32'hA000000};
  localparam logic [31:0] AF[4] = '{32'hFFFF, 32'h8000FFF, 32'h9000FFF,
                                   32'hA0000FF};
  localparam logic [7:0]  AK[4] = '{8'h0, 8'h1, 8'h2, 8'h3};
  localparam logic [31:0] AU[4] = '{32'h1000, 32'h40, 32'h0, 32'h100};

  logic        sys_clk_i, reset_i, rx_valid_i, rx_ready_o, tx_valid_o;
  logic        tx_ready_i, cmd_permitted_i, erase_req_o, erase_done_i;
  logic        erase_fault_i, busy_o;
  logic [7:0]  rx_byte_i, tx_byte_o, lifecycle_state_i;
  logic [31:0] erase_addr_o, flash_status_i;
  logic [31:0] units[$];
  int          n_errors = 0, checked = 0, cyc = 0, fault_at = 99;
  fec_pkg::fec_area_t [3:0] area_table_i;
  fec_pkg::fec_range_t      sec_r, prot_r;

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  fec_erase_handler #(
    .NONSECURE_DEBUG(NSD), .ST_PACKET_ERR(ST[0]), .ST_CHECKSUM_ERR(ST[1]),
    .ST_ACCEPT_ERR(ST[2]), .ST_PARAM_ERR(ST[3]), .ST_SECURE_ERR(ST[4]),
    .ST_PROTECT_ERR(ST[5]), .ST_FLASH_ERR(ST[6])
  ) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
    .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i),
    .lifecycle_state_i(lifecycle_state_i), .cmd_permitted_i(cmd_permitted_i),
    .debug_id_lock_i(1'b0), .id_authenticated_i(1'b0),
    .area_table_i(area_table_i), .secure_region_i(sec_r),
    .perm_protect_i(prot_r), .erase_req_o(erase_req_o),
    .erase_addr_o(erase_addr_o), .erase_done_i(erase_done_i),
    .erase_fault_i(erase_fault_i), .flash_status_i(flash_status_i),
    .busy_o(busy_o)
  );

  fec_host_model host (
    .sys_clk_i(sys_clk_i), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
    .tx_ready_o(tx_ready_i)
  );

  // ----------------------------------------------------------------
  // flash sequencer stand-in: random latency, fault on chosen unit
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    erase_done_i  <= 1'b0;
    erase_fault_i <= 1'b0;
    if (erase_req_o === 1'b1 && erase_done_i !== 1'b1 &&
        2'($random(host.seed)) == 2'h0) begin
      erase_done_i  <= 1'b1;
      erase_fault_i <= units.size() == fault_at;
      units.push_back(erase_addr_o);
    end
  end

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic int area_of(input logic [31:0] a);
    for (int i = 0; i < 4; i++) if (a >= AB[i] && a <= AF[i]) return i;
    return -1;
  endfunction

  function automatic bit hits(input fec_pkg::fec_range_t r,
                              input logic [31:0] b, f);
    return r.valid && b <= r.range_final_address && f >= r.range_begin_address;
  endfunction

  function automatic logic [7:0] model(input logic [31:0] b, f, input int bad,
                                       input logic ok, input logic [7:0] lc);
    int i, j;
    i = area_of(b);
    j = area_of(f);
    if (bad != 0) return bad == 2 ? ST[1] : ST[0];
    if (!ok) return ST[2];
    if (b > f || i < 0 || j < 0) return ST[3];
    if (AK[i] != AK[j] || AU[i] == 0) return ST[3];
    if (b % AU[i] != 0 || (f + 1) % AU[i] != 0) return ST[3];
    if (lc == NSD && hits(sec_r, b, f)) return ST[4];
    if (hits(prot_r, b, f)) return ST[5];
    return 8'h00;
  endfunction

  function automatic logic [7:0] csum(input logic [7:0] x[14]);
    logic [7:0] s;
    s = 8'h0;
    for (int k = 1; k < 12; k++) s += x[k];
    return 8'(8'h0 - s);
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one command frame, its reply and its erase units
  task automatic run(input logic [31:0] b, f, input int bad, input logic ok,
                     input logic [7:0] lc, input int fa);
    logic [7:0]  fr[14], ex[15], s, g;
    logic [31:0] a, d, eu[$];
    int          n;
    cmd_permitted_i   <= ok;
    lifecycle_state_i <= lc;
    fault_at = fa;
    units.delete();
    d = $random(host.seed);
    flash_status_i <= d;
    fr = '{8'h01, 8'h00, bad == 3 ? 8'h0A : 8'h09, 8'h12, b[31:24],
           b[23:16], b[15:8], b[7:0], f[31:24], f[23:16], f[15:8], f[7:0],
           8'h00, bad == 1 ? 8'h04 : 8'h03};
    fr[12] = csum(fr) + (bad == 2 ? 8'h01 : 8'h00);
    g = $random(host.seed);
    host.send(g == 8'h01 ? 8'h02 : g);
    foreach (fr[k]) host.send(fr[k]);
    host.idle();
    s = model(b, f, bad, ok, lc);
    if (s == 8'h00) begin
      for (a = b; a <= f; a += AU[area_of(b)]) begin
        eu.push_back(a);
        if (eu.size() == fa + 1) break;
      end
    end
    if (s == 8'h00 && eu.size() == fa + 1) begin
      s = ST[6];
      a = eu[fa];
    end else begin
      a = 32'hFFFFFFFF;
      d = 32'hFFFFFFFF;
    end
    ex = '{8'h81, 8'h00, 8'h0A, s == 8'h00 ? 8'h12 : 8'h92, s, d[31:24],
           d[23:16], d[15:8], d[7:0], a[31:24], a[23:16], a[15:8], a[7:0],
           8'h00, 8'h03};
    g = 8'h00;
    for (int k = 1; k < 13; k++) g += ex[k];
    ex[13] = 8'(8'h00 - g);
    n = 0;
    while (host.q.size() < 15 && n < 4000) begin
      @(posedge sys_clk_i);
      n++;
    end
    for (int k = 0; k < 15; k++) chk(host.q[k], ex[k], "reply byte");
    chk(units.size(), eu.size(), "unit count");
    foreach (eu[k]) chk(units[k], eu[k], "unit address");
    host.q.delete();
  endtask

  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    reset_i           = 1'b1;
    cmd_permitted_i   = 1'b1;
    lifecycle_state_i = 8'h00;
    erase_done_i      = 1'b0;
    erase_fault_i     = 1'b0;
    flash_status_i    = 32'h0;
    sec_r  = '{1'b1, 32'h8000, 32'h8FFF};
    prot_r = '{1'b1, 32'hE000, 32'hEFFF};
    for (int i = 0; i < 4; i++) area_table_i[i] = '{AB[i], AF[i], AK[i], AU[i]};
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    run(32'h0, 32'h1FFF, 0, 1'b1, 8'h00, 99);
    run(32'h8000000, 32'h80000FF, 0, 1'b1, 8'h00, 99);
    run(32'h0, 32'h2FFF, 0, 1'b1, 8'h00, 1);
    run(32'h8000000, 32'h80000FF, 0, 1'b1, 8'h00, 3);
    run(32'h0, 32'hFFF, 1, 1'b1, 8'h00, 99);
    run(32'h0, 32'hFFF, 2, 1'b1, 8'h00, 99);
    run(32'h0, 32'hFFF, 3, 1'b1, 8'h00, 99);
    run(32'h2000, 32'h1FFF, 1, 1'b0, 8'h00, 99);
    run(32'h2000, 32'h1FFF, 0, 1'b0, 8'h00, 99);
    run(32'h2000, 32'h1FFF, 0, 1'b1, 8'h00, 99);
    run(32'hFF000, 32'hFFFFF, 0, 1'b1, 8'h00, 99);
    run(32'h0, 32'h800003F, 0, 1'b1, 8'h00, 99);
    run(32'h9000000, 32'h90000FF, 0, 1'b1, 8'h00, 99);
    run(32'h10, 32'hFFF, 0, 1'b1, 8'h00, 99);
    run(32'h0, 32'hFFE, 0, 1'b1, 8'h00, 99);
    run(32'h7000, 32'h8FFF, 0, 1'b1, NSD, 99);
    run(32'h7000, 32'h8FFF, 0, 1'b1, 8'h00, 99);
    run(32'hD000, 32'hEFFF, 0, 1'b1, NSD, 99);
    run(32'h8000, 32'hEFFF, 0, 1'b1, NSD, 99);
    repeat (3) begin
      r = 32'h8000000 | (32'($random(host.seed)) & 32'hFC0);
      run(r, r + 32'h3F, 0, 1'b1, 8'h00, 99);
    end
    end_of_test();
  end
endmodule // tb_flash_erase_command_handler
